// ===== rtl/efs_fifo.sv
// word fifo between acquisition core and serial shifter
`timescale 1ns/10ps
module efs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
)(
  input  wire logic             clk,        // core clock
  input  wire logic             sys_rst,    // sync reset, active high
  input  wire logic [WIDTH-1:0] in_data,    // word to store
  input  wire logic             in_valid,   // in_data offered
  output logic                  in_ready,   // room left
  output logic      [WIDTH-1:0] out_data,   // oldest word
  output logic                  out_valid,  // fifo not empty
  input  wire logic             out_ready   // drain side takes word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE  = (AW+1)'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_ready & out_valid;
  assign out_data = mem[rd_ptr_q];

  always_comb
  begin
    cnt_d = cnt_q;
    if (push & ~pop)
      cnt_d = cnt_q + CNT_ONE;
    else if (pop & ~push)
      cnt_d = cnt_q - CNT_ONE;
  end

  // storage has no reset, pointers guard it
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end

  // pointers wrap naturally, depth is a power of two
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + AW'(1);
      if (pop)
        rd_ptr_q <= rd_ptr_q + AW'(1);
      cnt_q     <= cnt_d;
      in_ready  <= (cnt_d != CNT_FULL);
      out_valid <= (cnt_d != '0);
    end
  end
endmodule // efs_fifo

// ===== rtl/efs_pkg.sv
// shared constants and carrier types of the ecg frame serial slave
package efs_pkg;
  localparam int          WORD_BITS    = 32;     // command and long frame word
  localparam int          HALF_BITS    = 16;     // frame word at the fast rate
  localparam int          RESYNC_ONES  = 64;     // ones on sdi that force realign
  localparam int          RD_HANDSHAKE = 3;      // core cycles per read handshake
  localparam int          FIFO_DEPTH   = 8;      // words buffered toward the pin
  localparam int          CMD_RW_BIT   = 31;     // set: write, clear: read
  localparam int          ADDR_MSB     = 30;
  localparam int          ADDR_LSB     = 24;
  localparam int          DATA_MSB     = 23;
  localparam int          FRAME_SLOW   = 11;     // default words, 32-bit rates
  localparam int          FRAME_FAST   = 13;     // default words, 16-bit rate
  localparam int          FRAME_SLOW_MX = 12;    // all words, 32-bit rates
  localparam int          FRAME_FAST_MX = 15;    // all words, 16-bit rate
  localparam logic [6:0]  NOP_ADDR     = 7'h00;  // no_operation register
  localparam logic [6:0]  HDR_ADDR     = 7'h40;  // frame_header register
  localparam logic [2:0]  PIN_IDLE     = 3'h6;   // cs_n, sclk high; sdi low
  localparam logic [31:0] WORD_ZERO    = 32'h00000000;

  // one frame word as the acquisition core hands it over
  typedef struct packed {
    logic        last;   // final word of the frame
    logic [6:0]  addr;   // source register address
    logic [23:0] data;   // register contents
  } efs_word_type;

  // register write toward the core
  typedef struct packed {
    logic        stb;
    logic [6:0]  addr;
    logic [23:0] data;
  } efs_wr_type;
endpackage

// ===== rtl/efs_spi_slave.sv
// serial register and frame port of the ecg front end
// Behaviour
// - chip select high: ignore sdi, release sdo driver.
// - 64 ones on sdi realign; next word starts at first low bit.
// - sdi sampled on rising serial clock edges.
// - sdo changes on falling serial clock edges.
// - ready pin high in reset, frame state when framing, else low.
// - write takes effect at chip select rise or next word start.
// - bit 31 read/write flag, bits 30:24 address, 23:0 data.
// - read data returns in the word after the command.
// - fast rate frame words are 16 bits, upper register bits only.
// - slow rate frame words are 32 bits, address in upper byte.
// - read of header address starts framing until another command.
// - all-zero words address no_operation and keep framing alive.
// - chip select may toggle per word or stay low whole frame.
// - frames hold 11 or 13 words, up to 12 or 15.
// - any register read stops framing until header read again.
// - register read answers are 32 bits, msb first.
// - writes accepted while framing; here a write also ends framing.
// - ready held low until last frame bit is on sdo.
// - core to serial read answers take a three cycle handshake.
`timescale 1ns/10ps
module efs_spi_slave
  import efs_pkg::*;
(
  input  wire logic         clk,           // 200 MHz core clock
  input  wire logic         sys_rst,       // sync reset, active high
  input  wire logic         cs_n,          // chip select pin, active low
  input  wire logic         sclk,          // host serial clock pin
  input  wire logic         sdi,           // serial data in pin
  output logic              sdo,           // serial data out
  output logic              sdo_oe,        // high while sdo is driven
  output logic              frame_ready_n, // low when frame ready
  input  wire logic         rate_fast,     // 16-bit frame word rate
  input  wire efs_word_type word_in,       // frame word from core
  input  wire logic         word_valid,    // word_in offered
  output logic              word_ready,    // fifo has room
  input  wire logic         frame_loaded,  // pulse: full frame buffered
  output efs_wr_type        reg_wr,        // register write strobe
  output logic              rd_req,        // register read pulse
  output logic        [6:0] rd_addr,       // register read address
  input  wire logic  [23:0] rd_data        // register read contents
);
  logic [2:0]   pins_s;
  logic         cs_s;
  logic         sck_s;
  logic         sdi_s;
  logic         sck_prev_q;
  logic         cs_prev_q;
  logic         sck_rise;
  logic         sck_fall;
  logic         cs_rise;
  logic [5:0]   rx_cnt_q;
  logic [31:0]  rx_sh_q;
  logic [6:0]   ones_q;
  logic         hunt_q;
  logic         cmd_fire_q;
  logic [31:0]  cmd_q;
  logic         framing_q;
  logic         frame_avail_q;
  logic         wr_pend_q;
  efs_wr_type   wr_hold_q;
  logic [1:0]   rd_wait_q;
  logic         resp_pend_q;
  logic [31:0]  resp_q;
  logic [4:0]   tx_cnt_q;
  logic [5:0]   tx_len_q;
  logic [31:0]  tx_sh_q;
  logic         tx_last_q;
  logic         last_out;
  logic         tx_load;
  logic         hunt_exit;
  logic         peek_bit;
  logic         resp_take;
  logic         fifo_pop;
  logic         fifo_valid;
  efs_word_type fifo_word;
  logic         cmd_wr;
  logic [6:0]   cmd_addr;
  logic [31:0]  frame_word;

  efs_sync #(.W(3), .INIT(PIN_IDLE)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({cs_n, sclk, sdi}),
    .q       (pins_s)
  );

  efs_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (word_in),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .out_data  (fifo_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign cs_s     = pins_s[2];
  assign sck_s    = pins_s[1];
  assign sdi_s    = pins_s[0];
  assign sck_rise = sck_s & ~sck_prev_q & ~cs_s;
  assign sck_fall = ~sck_s & sck_prev_q & ~cs_s;
  assign cs_rise  = cs_s & ~cs_prev_q;
  assign cmd_wr   = cmd_q[CMD_RW_BIT];
  assign cmd_addr = cmd_q[ADDR_MSB:ADDR_LSB];

  // edge history of the synchronised pins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sck_prev_q <= 1'b1;
      cs_prev_q  <= 1'b1;
    end
    else
    begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_s;
    end
  end

  // receive shifter with ones counter for realignment
  always_ff @(posedge clk)
  begin
    if (sys_rst || cs_s)
    begin
      rx_cnt_q   <= '0;
      rx_sh_q    <= WORD_ZERO;
      ones_q     <= '0;
      hunt_q     <= 1'b0;
      cmd_fire_q <= 1'b0;
    end
    else
    begin
      cmd_fire_q <= 1'b0;
      if (sck_rise)
      begin
        if (!sdi_s)
          ones_q <= '0;
        else if (ones_q != 7'(RESYNC_ONES))
          ones_q <= ones_q + 7'h01;
        if (sdi_s && ones_q == 7'(RESYNC_ONES - 1))
        begin
          hunt_q   <= 1'b1;
          rx_cnt_q <= '0;
        end
        else if (!(hunt_q && sdi_s))
        begin
          hunt_q   <= 1'b0;
          rx_sh_q  <= {rx_sh_q[30:0], sdi_s};
          rx_cnt_q <= (rx_cnt_q == 6'(WORD_BITS)) ? 6'h01
                      : rx_cnt_q + 6'h01;
          if (rx_cnt_q == 6'(WORD_BITS - 1))
          begin
            cmd_fire_q <= 1'b1;
            cmd_q      <= {rx_sh_q[30:0], sdi_s};
          end
        end
      end
    end
  end

  // framing state follows each decoded command other than no_operation
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      framing_q <= 1'b0;
    else if (cmd_fire_q && cmd_addr != NOP_ADDR)
      framing_q <= !cmd_wr && cmd_addr == HDR_ADDR;
  end

  // writes wait for chip select rise or the next word's first rising edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_pend_q <= 1'b0;
      wr_hold_q <= '0;
      reg_wr    <= '0;
    end
    else
    begin
      reg_wr.stb <= 1'b0;
      if (wr_pend_q && (cs_rise || sck_rise))
      begin
        reg_wr    <= wr_hold_q;
        wr_pend_q <= 1'b0;
      end
      if (cmd_fire_q && cmd_wr && cmd_addr != NOP_ADDR)
      begin
        wr_pend_q <= 1'b1;
        wr_hold_q <= {1'b1, cmd_addr, cmd_q[DATA_MSB:0]};
      end
    end
  end

  // register read: request, wait the handshake, hold the answer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_req      <= 1'b0;
      rd_addr     <= '0;
      rd_wait_q   <= '0;
      resp_pend_q <= 1'b0;
      resp_q      <= WORD_ZERO;
    end
    else
    begin
      rd_req <= 1'b0;
      if (resp_take)
        resp_pend_q <= 1'b0;
      if (cmd_fire_q && !cmd_wr && cmd_addr != NOP_ADDR
          && cmd_addr != HDR_ADDR)
      begin
        rd_req    <= 1'b1;
        rd_addr   <= cmd_addr;
        rd_wait_q <= 2'h1;
      end
      else if (rd_wait_q != '0)
      begin
        rd_wait_q <= rd_wait_q + 2'h1;
        if (rd_wait_q == 2'(RD_HANDSHAKE - 1))
        begin
          rd_wait_q   <= '0;
          resp_pend_q <= 1'b1;                        // set wins over take
          resp_q      <= {1'b0, rd_addr, rd_data};
        end
      end
    end
  end

  // next word source decided at the first falling edge of a word
  // after a realign the first low bit on sdi marks bit 31 of the word, so
  // the word is loaded on that rise; its top bit was already peeked out
  assign hunt_exit = hunt_q && sck_rise && !sdi_s;
  assign tx_load   = (sck_fall && tx_cnt_q == '0 && !hunt_q) || hunt_exit;
  assign peek_bit  = resp_pend_q ? resp_q[31]
                     : (framing_q && !frame_ready_n && fifo_valid)
                     ? frame_word[31] : 1'b0;
  assign resp_take = tx_load && resp_pend_q;
  assign fifo_pop  = tx_load && !resp_pend_q && framing_q
                     && !frame_ready_n && fifo_valid;
  assign last_out  = sck_fall && tx_cnt_q != '0 && tx_last_q
                     && 6'(tx_cnt_q) == tx_len_q - 6'h01;

  // fast rate keeps the upper sixteen register bits only
  always_comb
  begin
    if (rate_fast)
      frame_word = {fifo_word.data[DATA_MSB -: HALF_BITS],
                    16'h0000};
    else
      frame_word = {1'b0, fifo_word.addr, fifo_word.data};
  end

  // transmit shifter, one bit per falling edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_cnt_q  <= '0;
      tx_len_q  <= 6'(WORD_BITS);
      tx_sh_q   <= WORD_ZERO;
      tx_last_q <= 1'b0;
      sdo       <= 1'b0;
    end
    else if (cs_s)
      tx_cnt_q <= '0;
    else if (tx_load)
    begin
      tx_cnt_q <= 5'h01;
      if (resp_take)
      begin
        sdo       <= resp_q[31];
        tx_sh_q   <= {resp_q[30:0], 1'b0};
        tx_len_q  <= 6'(WORD_BITS);
        tx_last_q <= 1'b0;
      end
      else if (fifo_pop)
      begin
        sdo       <= frame_word[31];
        tx_sh_q   <= {frame_word[30:0], 1'b0};
        tx_len_q  <= rate_fast ? 6'(HALF_BITS) : 6'(WORD_BITS);
        tx_last_q <= fifo_word.last;
      end
      else
      begin
        sdo       <= 1'b0;                            // idle filler word
        tx_sh_q   <= WORD_ZERO;
        tx_len_q  <= 6'(WORD_BITS);
        tx_last_q <= 1'b0;
      end
    end
    else if (hunt_q)
    begin
      tx_cnt_q <= '0;
      if (sck_fall)
        sdo <= peek_bit;  // alignment unknown yet, show next top bit
    end
    else if (sck_fall)
    begin
      sdo      <= tx_sh_q[31];
      tx_sh_q  <= {tx_sh_q[30:0], 1'b0};
      tx_cnt_q <= (6'(tx_cnt_q) == tx_len_q - 6'h01) ? 5'h00
                  : tx_cnt_q + 5'h01;
    end
  end

  // driver released whenever chip select is high
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sdo_oe <= 1'b0;
    else
      sdo_oe <= ~cs_s;
  end

  // frame availability; a new frame wins over the last-bit clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      frame_avail_q <= 1'b0;
    else if (frame_loaded)
      frame_avail_q <= 1'b1;
    else if (last_out)
      frame_avail_q <= 1'b0;
  end

  // ready pin: busy in reset, frame state while framing
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      frame_ready_n <= 1'b1;
    else if (framing_q)
      frame_ready_n <= ~frame_avail_q;
    else
      frame_ready_n <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence rd_issue_s;
    cmd_fire_q && !cmd_wr && cmd_addr != NOP_ADDR && cmd_addr != HDR_ADDR;
  endsequence

  sequence hdr_issue_s;
    cmd_fire_q && !cmd_wr && cmd_addr == HDR_ADDR;
  endsequence

  sdo_release_a : assert property (cs_s |=> !sdo_oe)
    else $error("sdo driven while deselected");
  resync_hunt_a : assert property (
    sck_rise && sdi_s && ones_q == 7'(RESYNC_ONES - 1) |=> hunt_q && rx_cnt_q == '0)
    else $error("no realign after long run of ones");
  rx_sample_a : assert property (
    sck_rise && !hunt_q && !(sdi_s && ones_q == 7'(RESYNC_ONES - 1))
    |=> rx_sh_q[0] == $past(sdi_s))
    else $error("sdi not sampled on rising edge");
  tx_edge_a : assert property ($changed(sdo) |-> $past(sck_fall))
    else $error("sdo moved off a falling edge");
  idle_ready_a : assert property (!framing_q |=> !frame_ready_n)
    else $error("ready not low outside framing");
  hdr_start_a : assert property (hdr_issue_s |=> framing_q)
    else $error("header read did not start framing");
  nop_keep_a : assert property (
    cmd_fire_q && cmd_addr == NOP_ADDR && framing_q |=> framing_q)
    else $error("no-op word broke framing");
  rd_stop_a : assert property (rd_issue_s |=> !framing_q)
    else $error("register read left framing on");
  rd_answer_a : assert property (
    rd_issue_s |=> rd_req ##2 resp_pend_q && resp_q[30:24] == rd_addr)
    else $error("read answer not ready after handshake");
  last_bit_a : assert property (
    last_out && !frame_loaded && framing_q |=> ##1 frame_ready_n)
    else $error("ready not raised after last frame bit");
endmodule // efs_spi_slave

// ===== rtl/efs_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module efs_sync
  import efs_pkg::*;
#(
  parameter int         W    = 3,
  parameter logic [2:0] INIT = PIN_IDLE
)(
  input  wire logic         clk,      // core clock
  input  wire logic         sys_rst,  // sync reset, active high
  input  wire logic [W-1:0] d,        // raw pins
  output logic      [W-1:0] q         // synchronised copy
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_q <= INIT[W-1:0];
      q      <= INIT[W-1:0];
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // efs_sync

// ===== tb/efs_host_model.sv
// host side serial master model that drives the frame port pins
`timescale 1ns/10ps
module efs_host_model (
  output logic        cs_n,      // chip select, active low
  output logic        sclk,      // serial clock, idles high
  output logic        sdi,       // serial data toward device
  input  wire logic   sdo_line,  // resolved serial data out
  output logic [31:0] rx_word,   // last word taken from sdo
  output logic        rx_done    // pulse: rx_word complete
);
  logic [31:0] rx;

  // idle pins: deselected, clock parked high
  initial
  begin
    cs_n    = 1'b1;
    sclk    = 1'b1;
    sdi     = 1'b0;
    rx_word = 32'h00000000;
    rx_done = 1'b0;
  end

  // n bits msb first; hold keeps cs low for the next word
  task automatic xfer(input logic [63:0] w, input int n, input bit hold,
                      input bit rep);
    rx = 32'h00000000;
    if (cs_n)
    begin
      cs_n = 1'b0;
      #40;
    end
    for (int i = n - 1; i >= 0; i--)
    begin
      // data moves on the fall so it is steady at the device's rise
      sclk = 1'b0;
      sdi  = w[i];
      #32;
      sclk = 1'b1; // 64 ns period, well under 40 MHz
      rx   = {rx[30:0], sdo_line};
      #32;
    end
    if (!hold)
    begin
      cs_n = 1'b1;
      sdi  = ~sdi; // a stale level would hide an ignored-input fault
      #100;
    end
    if (rep)
    begin
      rx_word = rx;
      rx_done = 1'b1;
      #5;
      rx_done = 1'b0;
    end
  endtask
endmodule // efs_host_model

// ===== tb/efs_spi_slave_tb.sv
// self-checking bench for the ecg frame serial slave
`timescale 1ns/10ps
module efs_spi_slave_tb
  import efs_pkg::*;
;
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         rate_fast = 1'b0;
  efs_word_type word_in = '0;
  logic         word_valid = 1'b0;
  logic         frame_loaded = 1'b0;
  logic  [23:0] rd_data = 24'h000000;
  logic         cs_n, sclk, sdi, sdo, sdo_oe, frame_ready_n, word_ready;
  logic         rd_req, rx_done;
  logic         rdy_prev = 1'b1;
  logic   [6:0] rd_addr;
  logic  [31:0] rx_word, rnd_v;
  logic  [31:0] seed = 32'h0BAB5401;
  efs_wr_type   reg_wr;
  wire          sdo_line = sdo_oe ? sdo : 1'bz;
  int           miscompares = 0;
  int           compares = 0;
  int           rises = 0;
  efs_word_type core_q[$];
  efs_word_type fr[$];
  logic  [31:0] exp_rx[$];
  logic  [31:0] exp_wr[$];
  logic  [31:0] exp_rd[$];

  always #2.5 clk = ~clk;

  efs_spi_slave uut (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .cs_n          (cs_n),
    .sclk          (sclk),
    .sdi           (sdi),
    .sdo           (sdo),
    .sdo_oe        (sdo_oe),
    .frame_ready_n (frame_ready_n),
    .rate_fast     (rate_fast),
    .word_in       (word_in),
    .word_valid    (word_valid),
    .word_ready    (word_ready),
    .frame_loaded  (frame_loaded),
    .reg_wr        (reg_wr),
    .rd_req        (rd_req),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data)
  );

  efs_host_model host (
    .cs_n     (cs_n),
    .sclk     (sclk),
    .sdi      (sdi),
    .sdo_line (sdo_line),
    .rx_word  (rx_word),
    .rx_done  (rx_done)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [63:0] cmd(input logic wr, input logic [6:0] a,
                                      input logic [23:0] d);
    return {32'h00000000, wr, a, d};
  endfunction

  // an empty queue yields a value no result can match
  function automatic logic [31:0] take(ref logic [31:0] q[$]);
    if (q.size() == 0)
      return 32'hFFFFFFFF;
    return q.pop_front();
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic word(input logic [63:0] w, input int n, input bit hold,
                      input logic [31:0] e);
    if (n == 16 || n == 32)
      exp_rx.push_back(e);
    host.xfer(w, n, hold, n == 16 || n == 32);
  endtask

  // queue one frame for the core feeder, header first
  task automatic load(input int n);
    efs_word_type f;
    fr.delete();
    for (int i = 0; i < n; i++)
    begin
      rnd_v  = rnd();
      f.last = (i == n - 1);
      f.addr = (i == 0) ? HDR_ADDR : 7'(i + 17);
      f.data = rnd_v[23:0];
      fr.push_back(f);
      core_q.push_back(f);
    end
  endtask

  // wait for the fifo to refuse, then announce the frame
  task automatic fill(input int left);
    for (int k = 0; k < 400 && word_ready !== 1'b0; k++)
      @(negedge clk);
    chk("fifo_full", 32'h0, {31'h0, word_ready});
    chk("fifo_kept", left, core_q.size());
    @(posedge clk) frame_loaded <= 1'b1;
    @(posedge clk) frame_loaded <= 1'b0;
  endtask

  // core side: offer the queue head, drop it once pushed
  always @(posedge clk)
  begin
    if (word_valid && word_ready === 1'b1 && core_q.size() != 0)
      void'(core_q.pop_front());
    word_valid <= (core_q.size() != 0);
    if (core_q.size() != 0)
      word_in <= core_q[0];
  end

  // result watchers: each strobe or word takes the oldest note
  always @(posedge clk)
  begin
    if (reg_wr.stb === 1'b1)
      chk("reg_wr", take(exp_wr), {1'b0, reg_wr.addr, reg_wr.data});
    if (rd_req === 1'b1)
      chk("rd_addr", take(exp_rd), {25'h0, rd_addr});
    if (!sys_rst && rdy_prev === 1'b0 && frame_ready_n === 1'b1)
      rises++;
    rdy_prev <= frame_ready_n;
  end

  always @(posedge rx_done)
    chk("rx_word", take(exp_rx), rx_word);

  // sequence of scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    chk("ready_rst", 32'h1, {31'h0, frame_ready_n});
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk("ready_idle", 32'h0, {31'h0, frame_ready_n});
    chk("oe_idle", 32'h0, {31'h0, sdo_oe});
    for (int k = 0; k < 3; k++)
    begin
      rnd_v = rnd();
      exp_wr.push_back({1'b0, 7'(k + 5), rnd_v[23:0]});
      word(cmd(1'b1, 7'(k + 5), rnd_v[23:0]), 32, k == 1, 32'h0);
    end
    load(FRAME_SLOW);
    fill(FRAME_SLOW - FIFO_DEPTH);
    word(cmd(1'b0, HDR_ADDR, 24'h0), 32, 1'b1, 32'h0);
    for (int i = 0; i < FRAME_SLOW - 1; i++)
      word(64'h0, 32, 1'b1, {1'b0, fr[i].addr, fr[i].data});
    chk("early_ready", 32'h0, rises);
    rnd_v = rnd();
    @(posedge clk) rd_data <= rnd_v[23:0];
    exp_rd.push_back(32'h1D);
    word(cmd(1'b0, 7'h1D, 24'h0), 32, 1'b1, {1'b0, fr[10].addr,
         fr[10].data});
    load(FRAME_FAST);
    word(64'h0, 32, 1'b1, {1'b0, 7'h1D, rd_data});
    word(64'h0, 32, 1'b0, 32'h0);
    chk("ready_rises", 32'h1, rises);
    fill(FRAME_FAST - FIFO_DEPTH);
    rate_fast <= 1'b1;
    word(cmd(1'b0, HDR_ADDR, 24'h0), 32, 1'b0, 32'h0);
    for (int i = 0; i < FRAME_FAST; i++)
      word(64'h0, 16, 1'b0, {16'h0, fr[i].data[23:8]});
    repeat (4) @(posedge clk);
    chk("ready_empty", 32'h1, {31'h0, frame_ready_n});
    rnd_v = rnd();
    exp_wr.push_back({1'b0, 7'h0C, rnd_v[23:0]});
    word(cmd(1'b1, 7'h0C, rnd_v[23:0]), 32, 1'b0, 32'h0);
    chk("ready_stop", 32'h0, {31'h0, frame_ready_n});
    chk("oe_off", 32'h0, {31'h0, sdo_oe});
    // lost alignment with cs held low, then realign
    rnd_v = rnd();
    @(posedge clk) rd_data <= rnd_v[31:8];
    rate_fast <= 1'b0;
    word(64'h0, 13, 1'b1, 32'h0);
    // the ones complete a word that writes all ones to address 7F
    exp_wr.push_back(32'h7FFFFFFF);
    word({64{1'b1}}, 64, 1'b1, 32'h0);
    exp_rd.push_back(32'h22);
    word(cmd(1'b0, 7'h22, 24'h0), 32, 1'b1, 32'h0);
    word(64'h0, 32, 1'b0, {1'b0, 7'h22, rd_data});
    repeat (4) @(posedge clk);
    chk("left_over", 32'h0, exp_rx.size() + exp_wr.size() + exp_rd.size());
    give_verdict();
  end

  // watchdog, nearly five times the expected run
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule // efs_spi_slave_tb
